/* src/fta_top.sv */
// Fan tachometer, pin configuration and alarm register block
`timescale 1ns/1ns
module fta_top
   import fta_pkg::*;
#(
   parameter int QUARTER_CYCLES = fta_pkg::GATE_BASE_CYCLES
)
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // Register access from the management front end
   input  wire logic [7:0]        reg_addr,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   input  wire logic [7:0]        reg_wdata,
   output logic [7:0]             reg_rdata,
   // Tachometer pulse inputs
   input  wire logic [3:0]        rotation_pulse,
   // Regulator side
   input  wire fta_pkg::fta_mode_t op_mode,
   input  wire logic              min_level_hit,
   input  wire logic              max_level_hit,
   output logic [7:0]             drive_level_code,
   output logic                   full_speed,
   // Open-drain line zero
   input  wire logic              io_line_zero_level,
   output logic                   io_line_zero_data,
   output logic                   io_line_zero_oe,
   // Open-drain line one
   input  wire logic              io_line_one_level,
   output logic                   io_line_one_data,
   output logic                   io_line_one_oe,
   // Open-drain line two
   input  wire logic              io_line_two_level,
   output logic                   io_line_two_data,
   output logic                   io_line_two_oe,
   // Open-drain line three
   input  wire logic              io_line_three_level,
   output logic                   io_line_three_data,
   output logic                   io_line_three_oe,
   // Open-drain line four
   input  wire logic              io_line_four_level,
   output logic                   io_line_four_data,
   output logic                   io_line_four_oe
);
   import fta_pkg::*;

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed
   {
      logic [7:0]  pin_def;     // Pin definition register
      logic [4:0]  alarm_en;    // Alarm enable bits
      logic [4:0]  alarm_stat;  // Sticky alarm status bits
      logic [1:0]  gate_code;   // Gating interval code
      logic [7:0]  drive;       // Drive level code
      logic [4:0]  io_s1;       // Pin sync stage one
      logic [4:0]  io_s2;       // Pin sync stage two
      logic [3:0]  rotation_pulse_overflow_s1;     // Pulse sync stage one
      logic [3:0]  rotation_pulse_overflow_s2;     // Pulse sync stage two
      logic [3:0]  rotation_pulse_overflow_prev;   // Previous synced pulse level
      logic        ext_prev;    // Previous synced line two level
      logic [31:0] base_cnt;    // Quarter second prescaler
      logic [2:0]  quarter_cnt; // Quarters inside this interval
      logic [7:0]  div_cnt;     // Clock output divider
      logic        clk_out;     // Clock output level
      logic [7:0]  rdata;       // Read data
   } fta_state_t;

   fta_state_t st;
   fta_state_t next_st;

   // Per-channel results
   logic [7:0] chan_count [4];  // Completed counts
   logic [3:0] chan_ovf;        // Completed interval overflows
   logic [3:0] pulse_edge;      // Rising pulse edges
   logic       gate_end;        // Last cycle of an interval
   logic       quarter_tick;    // End of a quarter second
   logic       time_en;         // Time base advance
   logic [4:0] io_raw;          // Pin levels gathered
   logic [4:0] alarm_cond;      // Live alarm causes
   logic       fault;           // Any latched alarm that is enabled
   logic [1:0] two_mode;        // Line two function
   logic [1:0] one_mode;        // Line one function
   logic [1:0] zero_mode;       // Line zero function
   logic [2:0] quarter_last;    // Quarters per interval minus one

   assign io_raw = {io_line_four_level, io_line_three_level,
                    io_line_two_level, io_line_one_level,
                    io_line_zero_level};
   assign two_mode  = st.pin_def[PD_TWO_HI:PD_TWO_LO];
   assign one_mode  = st.pin_def[PD_ONE_HI:PD_ONE_LO];
   assign zero_mode = st.pin_def[PD_ZERO_HI:PD_ZERO_LO];

   // ------------------------------------------------------------------
   // Tachometer channels
   // ------------------------------------------------------------------
   genvar ch;
   generate
      for (ch = 0; ch < 4; ch++)
      begin : g_chan
         // Edge from the second sync stage only
         assign pulse_edge[ch] = st.rotation_pulse_overflow_s2[ch] & ~st.rotation_pulse_overflow_prev[ch];

         fta_pulse_counter u_cnt
         (
            .clk        (clk),
            .rst_n      (rst_n),
            .pulse_edge (pulse_edge[ch]),
            .gate_end   (gate_end),
            .count      (chan_count[ch]),
            .overflow   (chan_ovf[ch])
         );
      end
   endgenerate

   // ------------------------------------------------------------------
   // Time base
   // ------------------------------------------------------------------
   // An external clock on line two replaces the internal time base
   assign time_en = (two_mode == PIN_CLK_IN)
                    ? (st.io_s2[2] & ~st.ext_prev) : 1'b1;
   assign quarter_tick = time_en &&
      (st.base_cnt == 32'(QUARTER_CYCLES - 1));
   // Interval is one, two, four or eight quarter seconds
   assign quarter_last = 3'((4'h1 << st.gate_code) - 4'h1);
   assign gate_end = quarter_tick && (st.quarter_cnt >= quarter_last);

   // ------------------------------------------------------------------
   // Alarm causes and fault flag
   // ------------------------------------------------------------------
   always_comb
   begin
      alarm_cond = 5'h00;
      alarm_cond[AL_LINE_TWO] = ~st.io_s2[2];
      alarm_cond[AL_LINE_ONE] = ~st.io_s2[1];
      alarm_cond[AL_OVERFLOW] = |chan_ovf;
      // Level alarms only while the loop regulates
      alarm_cond[AL_MIN] = min_level_hit &&
                           (op_mode == FTA_MODE_CLOSED);
      alarm_cond[AL_MAX] = max_level_hit &&
                           (op_mode == FTA_MODE_CLOSED);
   end

   // Status keeps bits whose enable was later cleared, so only enabled bits are a fault
   assign fault = |(st.alarm_stat & st.alarm_en);

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb
   begin
      next_st = st;

      // Two-stage synchronisers on every pin and pulse input
      next_st.io_s1     = io_raw;
      next_st.io_s2     = st.io_s1;
      next_st.rotation_pulse_overflow_s1   = rotation_pulse;
      next_st.rotation_pulse_overflow_s2   = st.rotation_pulse_overflow_s1;
      next_st.rotation_pulse_overflow_prev = st.rotation_pulse_overflow_s2;
      next_st.ext_prev  = st.io_s2[2];

      // Quarter second prescaler and interval position
      if (time_en)
      begin
         if (quarter_tick)
            next_st.base_cnt = 32'h0;
         else
            next_st.base_cnt = st.base_cnt + 32'h1;
      end
      if (gate_end)
         next_st.quarter_cnt = 3'h0;
      else if (quarter_tick)
         next_st.quarter_cnt = st.quarter_cnt + 3'h1;

      // Free-running clock output for line two
      if (st.div_cnt == 8'(CLK_OUT_HALF - 1))
      begin
         next_st.div_cnt = 8'h00;
         next_st.clk_out = ~st.clk_out;
      end
      else
         next_st.div_cnt = st.div_cnt + 8'h01;

      // Register writes
      if (reg_wr)
      begin
         case (reg_addr)
            ADDR_PIN_DEF:
               next_st.pin_def = reg_wdata;
            ADDR_ALARM_EN:
               next_st.alarm_en = reg_wdata[4:0];
            ADDR_GATING:
               next_st.gate_code = reg_wdata[1:0];
            ADDR_DRIVE:
               next_st.drive = reg_wdata;
            default:
               next_st.rdata = st.rdata;
         endcase
      end

      // Register reads, data held until the next read
      if (reg_rd)
      begin
         case (reg_addr)
            ADDR_COUNT0:     next_st.rdata = chan_count[0];
            ADDR_COUNT1:     next_st.rdata = chan_count[1];
            ADDR_COUNT2:     next_st.rdata = chan_count[2];
            ADDR_COUNT3:     next_st.rdata = chan_count[3];
            ADDR_PIN_STATUS: next_st.rdata = {3'h0, st.io_s2};
            ADDR_GATING:     next_st.rdata = {6'h00, st.gate_code};
            ADDR_PIN_DEF:    next_st.rdata = st.pin_def;
            ADDR_ALARM_EN:   next_st.rdata = {3'h0, st.alarm_en};
            ADDR_ALARM_STAT: next_st.rdata = {3'h0, st.alarm_stat};
            ADDR_DRIVE:      next_st.rdata = st.drive;
            default:         next_st.rdata = 8'h00;
         endcase
      end

      // Sticky status: read clears bits whose cause is gone,
      // and a live enabled cause always wins over the clear
      if (reg_rd && (reg_addr == ADDR_ALARM_STAT))
         next_st.alarm_stat = st.alarm_stat & alarm_cond;
      next_st.alarm_stat = next_st.alarm_stat |
                           (alarm_cond & st.alarm_en);
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st.pin_def     <= RST_PIN_DEF;
         st.alarm_en    <= RST_ALARM_EN;
         st.alarm_stat  <= RST_ALARM_STAT;
         st.gate_code   <= RST_GATING;
         st.drive       <= RST_DRIVE;
         st.io_s1       <= RST_LEVELS;
         st.io_s2       <= RST_LEVELS;
         st.rotation_pulse_overflow_s1     <= 4'h0;
         st.rotation_pulse_overflow_s2     <= 4'h0;
         st.rotation_pulse_overflow_prev   <= 4'h0;
         st.ext_prev    <= 1'b1;
         st.base_cnt    <= 32'h0;
         st.quarter_cnt <= 3'h0;
         st.div_cnt     <= 8'h00;
         st.clk_out     <= 1'b0;
         st.rdata       <= 8'h00;
      end
      else
         st <= next_st;
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign reg_rdata        = st.rdata;
   assign drive_level_code = st.drive;

   // Override input low forces the fan fully on
   assign full_speed = (one_mode == PIN_SPECIAL) &&
                       !st.io_s2[1];

   // Open-drain lines only ever pull low
   assign io_line_zero_data  = 1'b0;
   assign io_line_one_data   = 1'b0;
   assign io_line_two_data   = 1'b0;
   assign io_line_three_data = 1'b0;
   assign io_line_four_data  = 1'b0;

   // Line zero: fault flag pulls low while a fault is latched
   assign io_line_zero_oe = (zero_mode == PIN_DRIVE_LO) ||
      ((zero_mode == PIN_SPECIAL) && fault);

   // Line one: only drives in the low code
   assign io_line_one_oe = (one_mode == PIN_DRIVE_LO);

   // Line two: low code or low half of the clock output
   assign io_line_two_oe = (two_mode == PIN_DRIVE_LO) ||
      ((two_mode == PIN_SPECIAL) && !st.clk_out);

   // Lines three and four: a zero bit pulls the line low
   assign io_line_three_oe = !st.pin_def[PD_LINE_THREE];
   assign io_line_four_oe  = !st.pin_def[PD_LINE_FOUR];

endmodule // fta_top

/* src/fta_pkg.sv */
// Constants, register map and types for the fan tachometer and pin block
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
package fta_pkg;

   // Register command codes
   localparam logic [7:0] ADDR_COUNT0     = 8'h0c;
   localparam logic [7:0] ADDR_COUNT1     = 8'h0e;
   localparam logic [7:0] ADDR_COUNT2     = 8'h10;
   localparam logic [7:0] ADDR_COUNT3     = 8'h12;
   localparam logic [7:0] ADDR_PIN_STATUS = 8'h14;
   localparam logic [7:0] ADDR_GATING     = 8'h16;
   localparam logic [7:0] ADDR_PIN_DEF    = 8'h18;
   localparam logic [7:0] ADDR_ALARM_EN   = 8'h1a;
   localparam logic [7:0] ADDR_ALARM_STAT = 8'h1c;
   localparam logic [7:0] ADDR_DRIVE      = 8'h1e;

   // Reset values
   localparam logic [7:0] RST_PIN_DEF    = 8'hff;
   localparam logic [4:0] RST_ALARM_EN   = 5'h00;
   localparam logic [4:0] RST_ALARM_STAT = 5'h00;
   localparam logic [1:0] RST_GATING     = 2'h2;
   localparam logic [7:0] RST_DRIVE      = 8'h00;
   localparam logic [7:0] RST_COUNT      = 8'h00;
   localparam logic [4:0] RST_LEVELS     = 5'h1f;

   // Pin definition field positions
   localparam int PD_LINE_FOUR  = 7;
   localparam int PD_LINE_THREE = 6;
   localparam int PD_TWO_HI     = 5;
   localparam int PD_TWO_LO     = 4;
   localparam int PD_ONE_HI     = 3;
   localparam int PD_ONE_LO     = 2;
   localparam int PD_ZERO_HI    = 1;
   localparam int PD_ZERO_LO    = 0;

   // Alarm bit positions
   localparam int AL_LINE_TWO = 4;
   localparam int AL_LINE_ONE = 3;
   localparam int AL_OVERFLOW = 2;
   localparam int AL_MIN      = 1;
   localparam int AL_MAX      = 0;

   // Pin field codes
   localparam logic [1:0] PIN_CLK_IN   = 2'h0;
   localparam logic [1:0] PIN_SPECIAL  = 2'h1;
   localparam logic [1:0] PIN_DRIVE_LO = 2'h2;

   // Saturation value of a pulse count
   localparam logic [7:0] COUNT_MAX = 8'hff;

   // Timing
   localparam int CLK_PERIOD_NS     = 10;
   localparam int GATE_BASE_MS      = 250;
   localparam int GATE_BASE_CYCLES  =
      GATE_BASE_MS * 1000000 / CLK_PERIOD_NS;
   localparam int CLK_OUT_HALF      = 50;

   // Operating mode as presented by the regulator
   typedef enum logic [1:0]
   {
      FTA_MODE_FULL_ON = 2'h0,
      FTA_MODE_OFF     = 2'h1,
      FTA_MODE_CLOSED  = 2'h2,
      FTA_MODE_OPEN    = 2'h3
   } fta_mode_t;

endpackage

/* src/fta_pulse_counter.sv */
// One tachometer channel: pulse counter with interval latch
`timescale 1ns/1ns
module fta_pulse_counter
   import fta_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Events from the top
   input  wire logic       pulse_edge,
   input  wire logic       gate_end,
   // Results
   output logic [7:0]      count,
   output logic            overflow
);
   import fta_pkg::*;

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed
   {
      logic [7:0] run;      // Running pulse count
      logic       run_ovf;  // Running interval overflowed
      logic [7:0] count;    // Completed interval count
      logic       ovf;      // Completed interval overflowed
   } fta_cnt_state_t;

   fta_cnt_state_t st;
   fta_cnt_state_t next_st;

   // Count, saturate and latch at interval end
   always_comb
   begin
      next_st = st;
      if (gate_end)
      begin
         // Latch the finished interval, restart from zero, or from one if a pulse edge comes in the same cycle
         next_st.count   = st.run;
         next_st.ovf     = st.run_ovf;
         next_st.run     = pulse_edge ? 8'h01 : 8'h00;
         next_st.run_ovf = 1'b0;
      end
      else if (pulse_edge)
      begin
         // Saturate at full scale and remember the overflow
         if (st.run == COUNT_MAX)
            next_st.run_ovf = 1'b1;
         else
            next_st.run = st.run + 8'h01;
      end
   end

   // State register
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st.run     <= RST_COUNT;
         st.run_ovf <= 1'b0;
         st.count   <= RST_COUNT;
         st.ovf     <= 1'b0;
      end
      else
         st <= next_st;
   end

   assign count    = st.count;
   assign overflow = st.ovf;

endmodule // fta_pulse_counter

/* tb/fta_host_model.sv */
// Host model: register master that drives the block's register port
`timescale 1ns/1ns
module fta_host_model
(
   // Clock
   input  wire logic       clk,
   // Register port
   output logic [7:0]      reg_addr,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic [7:0]      reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   // Idle bus at time zero
   initial
   begin
      reg_addr  = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_wdata = 8'h00;
   end

   // One write; address and data scrambled once released
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
   endtask

   // One read; data is taken at the edge after the strobe edge,
   // where it stands until the next read, so callers resume on
   // a rising edge and drive their next stimulus there
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      @(posedge clk);
      d = reg_rdata;
   endtask
endmodule // fta_host_model

/* tb/fta_top_props.sv */
// Port-level assertions for the fan tachometer and pin block
`timescale 1ns/1ns
module fta_top_props
   import fta_pkg::*;
#(
   parameter int QUARTER_CYCLES = 20
)
(
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // Override and pins
   input wire logic       full_speed,
   input wire logic       io_line_one_level,
   input wire logic       io_line_zero_data,
   input wire logic       io_line_one_data,
   input wire logic       io_line_two_data,
   input wire logic       io_line_three_data,
   input wire logic       io_line_four_data,
   input wire logic       io_line_zero_oe,
   input wire logic       io_line_one_oe,
   input wire logic       io_line_two_oe,
   input wire logic       io_line_three_oe,
   input wire logic       io_line_four_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Open-drain lines never drive high
   property p_open_drain;
      !(io_line_zero_data | io_line_one_data | io_line_two_data
        | io_line_three_data | io_line_four_data);
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("pin data driven high");
   // Pin bits follow a definition write
   property p_four_oe;
      reg_wr && reg_addr == ADDR_PIN_DEF
         |=> io_line_four_oe == !$past(reg_wdata[7]);
   endproperty
   a_four_oe: assert property (p_four_oe)
      else $error("line four enable wrong");
   property p_three_oe;
      reg_wr && reg_addr == ADDR_PIN_DEF
         |=> io_line_three_oe == !$past(reg_wdata[6]);
   endproperty
   a_three_oe: assert property (p_three_oe)
      else $error("line three enable wrong");
   property p_two_low;
      reg_wr && reg_addr == ADDR_PIN_DEF && reg_wdata[5:4] == 2'h2
         |=> io_line_two_oe;
   endproperty
   a_two_low: assert property (p_two_low)
      else $error("line two not pulled low");
   property p_one_low;
      reg_wr && reg_addr == ADDR_PIN_DEF && reg_wdata[3:2] == 2'h2
         |=> io_line_one_oe;
   endproperty
   a_one_low: assert property (p_one_low)
      else $error("line one not pulled low");
   property p_zero_low;
      reg_wr && reg_addr == ADDR_PIN_DEF && reg_wdata[1:0] == 2'h2
         |=> io_line_zero_oe;
   endproperty
   a_zero_low: assert property (p_zero_low)
      else $error("line zero not pulled low");
   // Unused upper bits read zero
   property p_status_upper;
      reg_rd && reg_addr == ADDR_PIN_STATUS |=> reg_rdata[7:5] == 3'h0;
   endproperty
   a_status_upper: assert property (p_status_upper)
      else $error("pin status upper bits set");
   property p_gating_upper;
      reg_rd && reg_addr == ADDR_GATING |=> reg_rdata[7:2] == 6'h00;
   endproperty
   a_gating_upper: assert property (p_gating_upper)
      else $error("interval upper bits set");
   property p_enable_upper;
      reg_rd && reg_addr == ADDR_ALARM_EN |=> reg_rdata[7:5] == 3'h0;
   endproperty
   a_enable_upper: assert property (p_enable_upper)
      else $error("enable upper bits set");
   property p_alarm_upper;
      reg_rd && reg_addr == ADDR_ALARM_STAT |=> reg_rdata[7:5] == 3'h0;
   endproperty
   a_alarm_upper: assert property (p_alarm_upper)
      else $error("alarm upper bits set");
   // Override only follows a low line, two sync stages late
   property p_override;
      full_speed |-> !$past(io_line_one_level, 2);
   endproperty
   a_override: assert property (p_override)
      else $error("full speed without low line one");
endmodule // fta_top_props

bind fta_top fta_top_props #(.QUARTER_CYCLES(QUARTER_CYCLES)) i_props
(
   .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .full_speed(full_speed), .io_line_one_level(io_line_one_level),
   .io_line_zero_data(io_line_zero_data),
   .io_line_one_data(io_line_one_data),
   .io_line_two_data(io_line_two_data),
   .io_line_three_data(io_line_three_data),
   .io_line_four_data(io_line_four_data),
   .io_line_zero_oe(io_line_zero_oe), .io_line_one_oe(io_line_one_oe),
   .io_line_two_oe(io_line_two_oe), .io_line_three_oe(io_line_three_oe),
   .io_line_four_oe(io_line_four_oe)
);

/* tb/fta_top_tb_top.sv */
// Self-checking bench for the fan tachometer and pin block
`timescale 1ns/1ns
module fta_top_tb_top;
   import fta_pkg::*;
   localparam int QC = 20;                  // Shortened quarter interval
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, drive_level_code;
   logic       reg_wr, reg_rd, full_speed;
   logic [3:0] rotation_pulse = 4'h0;
   fta_mode_t  op_mode = FTA_MODE_FULL_ON;
   logic       min_level_hit = 1'b0;
   logic       max_level_hit = 1'b0;
   logic [4:0] ext_lvl = 5'h1f;             // Outside drive, pull-up high
   logic [4:0] oe, dat, lvl;
   logic [7:0] v, m, e, d;
   int         errors = 0;
   int         checks = 0;
   int         seed = 56;
   int         pc = 0;
   int         per [4] = '{5, 10, 20, 4};   // Pulse period per channel
   assign lvl = ext_lvl & ~oe;              // Wired level of each line

   always #5 clk = ~clk;
   // Periodic rotation_pulse_overflow pulses, high for two cycles
   always @(posedge clk)
   begin
      pc <= pc + 1;
      for (int c = 0; c < 4; c++)
         rotation_pulse[c] <= (pc % per[c]) < 2;
   end

   fta_host_model i_host (.clk(clk), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata));
   fta_top #(.QUARTER_CYCLES(QC)) i_dut (.clk(clk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .rotation_pulse(rotation_pulse), .op_mode(op_mode),
      .min_level_hit(min_level_hit), .max_level_hit(max_level_hit),
      .drive_level_code(drive_level_code), .full_speed(full_speed),
      .io_line_zero_level(lvl[0]), .io_line_zero_data(dat[0]),
      .io_line_zero_oe(oe[0]), .io_line_one_level(lvl[1]),
      .io_line_one_data(dat[1]), .io_line_one_oe(oe[1]),
      .io_line_two_level(lvl[2]), .io_line_two_data(dat[2]),
      .io_line_two_oe(oe[2]), .io_line_three_level(lvl[3]),
      .io_line_three_data(dat[3]), .io_line_three_oe(oe[3]),
      .io_line_four_level(lvl[4]), .io_line_four_data(dat[4]),
      .io_line_four_oe(oe[4]));

   // Compare and count
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] x);
      logic [7:0] r;
      i_host.rd(a, r);
      chk(r, x);
   endtask
   task automatic wait_c(input int n);
      repeat (n) @(posedge clk);
   endtask
   // External time base edges on line two
   task automatic edges(input int n);
      repeat (n)
      begin
         ext_lvl[2] <= 1'b0;
         wait_c(4);
         ext_lvl[2] <= 1'b1;
         wait_c(4);
      end
   endtask
   // Expected pull-down enables with no alarm active
   function automatic logic [4:0] exp_oe(input logic [7:0] p);
      return {~p[7], ~p[6], p[5:4] == 2'h2, p[3:2] == 2'h2,
              p[1:0] == 2'h2};
   endfunction
   task automatic wrap_up;
      if (errors == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Watchdog: far beyond the few thousand cycles the tests need
   initial
   begin
      wait_c(100000);
      errors++;
      wrap_up;
   end

   initial
   begin
      wait_c(12);
      rst_n <= 1'b1;
      // Reset values; read-only and unmapped writes ignored
      i_host.wr(ADDR_PIN_STATUS, 8'h00);
      i_host.wr(8'h00, 8'hff);
      rdc(8'h00, 8'h00);
      rdc(ADDR_PIN_DEF, 8'hff);
      rdc(ADDR_PIN_STATUS, 8'h1f);
      rdc(ADDR_GATING, 8'h02);
      rdc(ADDR_ALARM_EN, 8'h00);
      rdc(ADDR_ALARM_STAT, 8'h00);
      for (int c = 0; c < 4; c++)
         rdc(ADDR_COUNT0 + 8'(2 * c), 8'h00);
      // Pin functions and sampled levels, corners then random
      for (int i = 0; i < 8; i++)
      begin
         v = (i == 0) ? 8'h2a : (i == 1) ? 8'hf7 : 8'($random(seed));
         ext_lvl <= (i == 1) ? 5'h1d : 5'($random(seed));
         i_host.wr(ADDR_PIN_DEF, v);
         wait_c(6);
         m = (v[5:4] == 2'h1) ? 8'hfb : 8'hff;
         e = {3'h0, ext_lvl & ~exp_oe(v)};
         i_host.rd(ADDR_PIN_STATUS, d);
         chk(d & m, e & m);
         chk(8'(oe & m[4:0]), 8'(exp_oe(v) & m[4:0]));
         chk(8'(full_speed), 8'(v[3:2] == 2'h1 && !ext_lvl[1]));
         rdc(ADDR_PIN_DEF, v);
      end
      ext_lvl <= 5'h1f;
      i_host.wr(ADDR_PIN_DEF, 8'hff);
      // Every interval code, upper bits written but ignored
      for (int k = 0; k < 4; k++)
      begin
         i_host.wr(ADDR_GATING, 8'(k) | 8'hfc);
         wait_c(3 * (QC << k) + 8);
         rdc(ADDR_GATING, 8'(k));
         for (int c = 0; c < 4; c++)
            rdc(ADDR_COUNT0 + 8'(2 * c), 8'((QC << k) / per[c]));
      end
      // Stall the external time base so one interval overflows
      i_host.wr(ADDR_GATING, 8'h00);
      i_host.wr(ADDR_ALARM_EN, 8'h04);
      i_host.wr(ADDR_PIN_DEF, 8'hcd);
      edges(QC);
      wait_c(1200);
      edges(QC);
      wait_c(8);
      rdc(ADDR_COUNT3, 8'hff);
      rdc(ADDR_ALARM_STAT, 8'h04);
      rdc(ADDR_ALARM_STAT, 8'h04);
      chk(8'(oe[0]), 8'h01);
      // Back to the internal base: cause goes, read clears
      i_host.wr(ADDR_PIN_DEF, 8'hfd);
      wait_c(100);
      rdc(ADDR_ALARM_STAT, 8'h04);
      rdc(ADDR_ALARM_STAT, 8'h00);
      chk(8'(oe[0]), 8'h00);
      // Pin and level alarms against enables and mode
      i_host.wr(ADDR_ALARM_EN, 8'h00);
      ext_lvl[1] <= 1'b0;
      op_mode <= FTA_MODE_OPEN;
      min_level_hit <= 1'b1;
      max_level_hit <= 1'b1;
      wait_c(8);
      rdc(ADDR_ALARM_STAT, 8'h00);
      i_host.wr(ADDR_ALARM_EN, 8'hff);
      wait_c(8);
      rdc(ADDR_ALARM_EN, 8'h1f);
      rdc(ADDR_ALARM_STAT, 8'h08);
      op_mode <= FTA_MODE_CLOSED;
      wait_c(4);
      rdc(ADDR_ALARM_STAT, 8'h0b);
      chk(8'(oe[0]), 8'h01);
      ext_lvl[1] <= 1'b1;
      min_level_hit <= 1'b0;
      max_level_hit <= 1'b0;
      wait_c(8);
      rdc(ADDR_ALARM_STAT, 8'h0b);
      rdc(ADDR_ALARM_STAT, 8'h00);
      chk(8'(oe[0]), 8'h00);
      // Drive level code, reset value then random
      rdc(ADDR_DRIVE, 8'h00);
      repeat (4)
      begin
         v = 8'($random(seed));
         i_host.wr(ADDR_DRIVE, v);
         rdc(ADDR_DRIVE, v);
         chk(drive_level_code, v);
      end
      wrap_up;
   end
endmodule // fta_top_tb_top
